//--- rtl/flash_access_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the flash access block.
  Assumes inclusion once per compilation unit, guarded below.
*/
`ifndef FLASH_ACCESS_DEFINES_SVH
`define FLASH_ACCESS_DEFINES_SVH
`define FPC_OFFSET 8'h29
`define FPC_RESET 8'h00
`define FPC_BIT_LATCH 0
`define FPC_BIT_PGM 1
`define FPC_BIT_SECT_ERASE 2
`define FPC_BIT_MASS_ERASE 3
`define FPC_BIT_BUSY 7
`define GUARD_OFFSET 8'h2A
`define GUARD_KEY1 8'h56
`define GUARD_KEY2 8'hAE
`define OPT_OFFSET 8'h2B
`define OPT_BIT_LOCK 0
`define OPT_BIT_REQ 1
`define MODE_OFFSET 8'h2C
`define ADDR_LO_OFFSET 8'h2D
`define ADDR_HI_OFFSET 8'h2E
`define DATA_OFFSET 8'h2F
`define SECTOR_BYTES 4096
`define SECTOR0_BASE 16'hF000
`define SECTOR1_BASE 16'hE000
`define PROG_TIME_NS 200
`define PROG_CYCLES ((`PROG_TIME_NS + 39) / 40)
`endif

//--- rtl/flash_access_pkg.sv
/*
  Types shared by the flash access block.
  Assumes the defines header is available on the include path.
*/
package flash_access_pkg;
  typedef enum logic [1:0] {
    MODE_APP = 2'b00,
    MODE_SELF = 2'b01,
    MODE_ONBOARD = 2'b10,
    MODE_TOOL = 2'b11
  } prog_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROG = 3'b001,
    ST_SERASE = 3'b010,
    ST_MERASE = 3'b011,
    ST_UNLOCK = 3'b100
  } op_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
endpackage

//--- rtl/pin_sync.sv
/*
  Two-stage synchroniser for one level from outside the clock domain.
  Assumes an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module pin_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic meta_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- rtl/flash_access_protect.sv
/*
  Access and protection logic of a sectored program flash with an in-circuit serial link.
  Assumes a register port on I_CLOCK and a tool that owns reset during a session.
*/
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "flash_access_defines.svh"
module flash_access_protect #(
  parameter int FLASH_KB = 8,
  parameter int PROG_CYCLES = `PROG_CYCLES
) (
  // Clock and reset.
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // Register port.
  input wire flash_access_pkg::reg_req_s I_REQ,
  output logic [7:0] O_RDATA,
  // In-circuit link pins.
  input wire logic I_SERIAL_CLOCK,
  input wire logic I_SERIAL_DATA,
  output logic O_SERIAL_DATA,
  output logic O_SERIAL_DATA_OE,
  input wire logic I_TOOL_ATTACHED,
  // Status outputs.
  output logic O_READOUT_LOCKED,
  output logic O_BUSY,
  output logic O_LINK_PINS_RESERVED
);
  import flash_access_pkg::*;
  localparam int ARRAY_BYTES = FLASH_KB * 1024;
  localparam int NSECT = (FLASH_KB <= 4) ? 1 : (FLASH_KB <= 8) ? 2 : 3;
  localparam int AW = $clog2(ARRAY_BYTES);

  initial begin
    if (FLASH_KB < 4 || FLASH_KB > 32 || (FLASH_KB % 4) != 0) begin
      $error("FLASH_KB must be a multiple of 4 from 4 to 32.");
    end
    if (PROG_CYCLES < 1) begin
      $error("PROG_CYCLES must be at least 1.");
    end
  end

  logic [7:0] mem [0:ARRAY_BYTES-1];
  logic [7:0] fpc_q, fpc_d;
  logic [1:0] guard_q, guard_d;
  logic lock_q, lock_d;
  prog_mode_e mode_q, mode_d;
  op_state_e st_q, st_d;
  logic [15:0] addr_q;
  logic [7:0] data_q;
  logic [AW-1:0] cnt_q, cnt_d;
  logic [15:0] wait_q, wait_d;
  logic [2:0] sclk_hist_q;
  logic sclk_s, sdata_s, attached_s;
  logic [7:0] shift_q;
  logic [2:0] bitcnt_q;
  logic link_byte_q;

  pin_sync u_sync_clk (.clk(I_CLOCK), .arst_n(I_ARST_N), .d(I_SERIAL_CLOCK), .q(sclk_s));
  pin_sync u_sync_dat (.clk(I_CLOCK), .arst_n(I_ARST_N), .d(I_SERIAL_DATA), .q(sdata_s));
  pin_sync u_sync_att (.clk(I_CLOCK), .arst_n(I_ARST_N), .d(I_TOOL_ATTACHED), .q(attached_s));

  wire wr_fpc = I_REQ.wr && I_REQ.addr == `FPC_OFFSET;
  wire wr_guard = I_REQ.wr && I_REQ.addr == `GUARD_OFFSET;
  wire wr_opt = I_REQ.wr && I_REQ.addr == `OPT_OFFSET;
  wire wr_mode = I_REQ.wr && I_REQ.addr == `MODE_OFFSET;
  wire wr_alo = I_REQ.wr && I_REQ.addr == `ADDR_LO_OFFSET;
  wire wr_ahi = I_REQ.wr && I_REQ.addr == `ADDR_HI_OFFSET;
  wire wr_dat = I_REQ.wr && I_REQ.addr == `DATA_OFFSET;
  wire busy = st_q != ST_IDLE;
  wire sclk_rise = sclk_hist_q[1] && !sclk_hist_q[2];
  // Sector index: sector 0 at F000-FFFF, sector 1 below it, the rest is sector 2.
  wire [1:0] sect_of_addr = (addr_q >= `SECTOR0_BASE) ? 2'd0 : (addr_q >= `SECTOR1_BASE) ? 2'd1 : 2'd2;
  wire [15:0] array_base = 16'(17'h10000 - 17'(ARRAY_BYTES));
  wire in_array = addr_q >= array_base;
  wire sect_present = {30'd0, sect_of_addr} < NSECT;
  wire [AW-1:0] mem_idx = AW'(addr_q - array_base);
  // Sector 0 stays closed in self programming; application mode has no write access.
  wire mode_ok = (mode_q == MODE_ONBOARD || mode_q == MODE_TOOL) ||
                 (mode_q == MODE_SELF && sect_of_addr != 2'd0);
  wire target_ok = in_array && sect_present && mode_ok && !lock_q;
  wire unlocked = guard_q == 2'd2;
  wire start_ok = wr_fpc && unlocked && !busy && I_REQ.wdata[`FPC_BIT_LATCH];
  wire opt_full = mode_q == MODE_ONBOARD || mode_q == MODE_TOOL;
  wire mass_ok = opt_full && !lock_q;
  wire [AW-1:0] sect_first = AW'(addr_q - array_base) & ~AW'(`SECTOR_BYTES - 1);
  wire [AW-1:0] sect_last = sect_first | AW'(`SECTOR_BYTES - 1);
  wire wait_done = wait_q == 16'd0;
  wire [AW-1:0] erase_last = (st_q == ST_MERASE || st_q == ST_UNLOCK) ? AW'(ARRAY_BYTES - 1) : sect_last;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wait_d = wait_done ? 16'd0 : wait_q - 16'd1;
    fpc_d = fpc_q;
    guard_d = guard_q;
    lock_d = lock_q;
    mode_d = mode_q;
    if (wr_guard) begin
      guard_d = (I_REQ.wdata == `GUARD_KEY1) ? 2'd1 :
                (I_REQ.wdata == `GUARD_KEY2 && guard_q == 2'd1) ? 2'd2 : 2'd0;
    end
    if (wr_mode && !busy) begin
      mode_d = prog_mode_e'(I_REQ.wdata[1:0]);
    end
    if (wr_fpc && !busy) begin
      fpc_d = {1'b0, I_REQ.wdata[6:0]};
    end
    if (wr_opt && opt_full && !busy) begin
      if (I_REQ.wdata[`OPT_BIT_LOCK]) begin
        lock_d = 1'b1;
      end else if (lock_q) begin
        st_d = ST_UNLOCK;
        cnt_d = '0;
        wait_d = 16'(PROG_CYCLES);
      end
    end
    if (start_ok) begin
      guard_d = 2'd0;
      if (I_REQ.wdata[`FPC_BIT_MASS_ERASE] && mass_ok) begin
        st_d = ST_MERASE;
        cnt_d = '0;
        wait_d = 16'(PROG_CYCLES);
      end else if (I_REQ.wdata[`FPC_BIT_SECT_ERASE] && target_ok) begin
        st_d = ST_SERASE;
        cnt_d = sect_first;
        wait_d = 16'(PROG_CYCLES);
      end else if (I_REQ.wdata[`FPC_BIT_PGM] && target_ok) begin
        st_d = ST_PROG;
        wait_d = 16'(PROG_CYCLES);
      end
    end
    if (busy && wait_done) begin
      if (st_q == ST_PROG || cnt_q == erase_last) begin
        st_d = ST_IDLE;
        fpc_d = `FPC_RESET;
        if (st_q == ST_UNLOCK) begin
          lock_d = 1'b0;
        end
      end else begin
        cnt_d = cnt_q + AW'(1);
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (busy && wait_done) begin
      if (st_q == ST_PROG) begin
        mem[mem_idx] <= mem[mem_idx] & data_q;
      end else begin
        mem[cnt_q] <= 8'hFF;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      wait_q <= 16'd0;
      fpc_q <= `FPC_RESET;
      guard_q <= 2'd0;
      lock_q <= 1'b0;
      mode_q <= MODE_APP;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wait_q <= wait_d;
      fpc_q <= fpc_d;
      guard_q <= guard_d;
      lock_q <= lock_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end else begin
      if (wr_alo && !busy) begin
        addr_q[7:0] <= I_REQ.wdata;
      end
      if (wr_ahi && !busy) begin
        addr_q[15:8] <= I_REQ.wdata;
      end
      if (wr_dat && !busy) begin
        data_q <= I_REQ.wdata;
      end
    end
  end

  // Reading the data port returns the array byte, masked while read-out lock is on.
  wire [7:0] array_byte = (in_array && !lock_q) ? mem[mem_idx] : 8'h00;
  wire [7:0] fpc_view = {busy, fpc_q[6:0]};
  wire [7:0] rd_mux = (I_REQ.addr == `FPC_OFFSET) ? fpc_view :
                      (I_REQ.addr == `OPT_OFFSET) ? {7'd0, lock_q} :
                      (I_REQ.addr == `MODE_OFFSET) ? {6'd0, mode_q} :
                      (I_REQ.addr == `ADDR_LO_OFFSET) ? addr_q[7:0] :
                      (I_REQ.addr == `ADDR_HI_OFFSET) ? addr_q[15:8] :
                      (I_REQ.addr == `DATA_OFFSET) ? array_byte : 8'h00;

  // Link receiver: shift data on serial clock rising edges, answer with the locked status bit.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sclk_hist_q <= 3'b000;
      shift_q <= 8'h00;
      bitcnt_q <= 3'd0;
      link_byte_q <= 1'b0;
    end else begin
      sclk_hist_q <= {sclk_hist_q[1:0], sclk_s};
      link_byte_q <= 1'b0;
      if (!attached_s) begin
        bitcnt_q <= 3'd0;
      end else if (sclk_rise) begin
        shift_q <= {shift_q[6:0], sdata_s};
        bitcnt_q <= bitcnt_q + 3'd1;
        link_byte_q <= bitcnt_q == 3'd7;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 8'h00;
      O_SERIAL_DATA <= 1'b0;
      O_SERIAL_DATA_OE <= 1'b0;
      O_READOUT_LOCKED <= 1'b0;
      O_BUSY <= 1'b0;
      O_LINK_PINS_RESERVED <= 1'b0;
    end else begin
      O_RDATA <= I_REQ.rd ? rd_mux : 8'h00;
      O_SERIAL_DATA <= lock_q;
      O_SERIAL_DATA_OE <= attached_s && link_byte_q;
      O_READOUT_LOCKED <= lock_q;
      O_BUSY <= busy;
      O_LINK_PINS_RESERVED <= attached_s;
    end
  end
endmodule

//--- verification/flash_access_protect_props.sv
/* Concurrent checks on the ports of the flash access block.
   Assumes the bind below and one clock domain on I_CLOCK. */
`timescale 1ns/1ns
module flash_access_protect_props #(
  parameter int PROG_CYCLES = 1
) (
  // Clock, reset and register port.
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  input wire flash_access_pkg::reg_req_s I_REQ,
  input wire logic [7:0] O_RDATA,
  // Link pins and status.
  input wire logic I_SERIAL_CLOCK,
  input wire logic I_SERIAL_DATA,
  input wire logic O_SERIAL_DATA,
  input wire logic O_SERIAL_DATA_OE,
  input wire logic I_TOOL_ATTACHED,
  input wire logic O_READOUT_LOCKED,
  input wire logic O_BUSY,
  input wire logic O_LINK_PINS_RESERVED
);
  import flash_access_pkg::*;
  logic key1_q;
  logic armed_q;
  int busy_cnt_q;
  wire wr_ctl = I_REQ.wr && I_REQ.addr == 8'h29 && I_REQ.wdata[0];
  wire wr_key = I_REQ.wr && I_REQ.addr == 8'h2A;
  wire set_lock = I_REQ.wr && I_REQ.addr == 8'h2B && I_REQ.wdata[0];
  wire rd_win = I_REQ.rd && I_REQ.addr == 8'h2F;
  // Tracks the unlock sequence and the length of each busy period.
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      key1_q <= 1'b0;
      armed_q <= 1'b0;
      busy_cnt_q <= 0;
    end else begin
      key1_q <= wr_key ? I_REQ.wdata == 8'h56 : key1_q;
      armed_q <= wr_key ? key1_q && I_REQ.wdata == 8'hAE : armed_q && !wr_ctl;
      busy_cnt_q <= O_BUSY ? busy_cnt_q + 1 : 0;
    end
  end
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  a_reset_quiet: assert property ($rose(I_ARST_N) |-> !O_BUSY && O_RDATA == 8'h00)
    else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (!$past(I_REQ.rd) |-> O_RDATA == 8'h00)
    else $error("read data without a read");
  a_guard_needed: assert property ($rose(O_BUSY) && $past(wr_ctl, 2) |-> $past(armed_q, 2))
    else $error("operation started without unlock");
  a_busy_span: assert property ($fell(O_BUSY) |-> busy_cnt_q >= PROG_CYCLES + 1)
    else $error("busy period too short");
  a_oe_pulse: assert property (O_SERIAL_DATA_OE |=> !O_SERIAL_DATA_OE)
    else $error("data enable longer than one cycle");
  a_oe_lock: assert property (O_SERIAL_DATA_OE |-> O_SERIAL_DATA == O_READOUT_LOCKED)
    else $error("link data differs from lock");
  a_attach_reserve: assert property ($rose(I_TOOL_ATTACHED) |-> ##[1:4] O_LINK_PINS_RESERVED)
    else $error("link pins not reserved");
  a_lock_cause: assert property ($rose(O_READOUT_LOCKED) |-> $past(set_lock) || $past(set_lock, 2))
    else $error("lock set without option write");
  a_unlock_erase: assert property ($fell(O_READOUT_LOCKED) |-> $past(O_BUSY) || $past(O_BUSY, 2))
    else $error("lock lifted without erase");
  a_locked_hidden: assert property (O_READOUT_LOCKED && $past(rd_win) |-> O_RDATA == 8'h00)
    else $error("flash data visible while locked");
endmodule
bind flash_access_protect flash_access_protect_props #(.PROG_CYCLES(PROG_CYCLES)) i_flash_access_protect_props (
  .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_REQ(I_REQ), .O_RDATA(O_RDATA), .I_SERIAL_CLOCK(I_SERIAL_CLOCK),
  .I_SERIAL_DATA(I_SERIAL_DATA), .O_SERIAL_DATA(O_SERIAL_DATA), .O_SERIAL_DATA_OE(O_SERIAL_DATA_OE),
  .I_TOOL_ATTACHED(I_TOOL_ATTACHED), .O_READOUT_LOCKED(O_READOUT_LOCKED), .O_BUSY(O_BUSY),
  .O_LINK_PINS_RESERVED(O_LINK_PINS_RESERVED));

//--- verification/icc_tool_model.sv
/* Programming tool model at the far side of the link pins.
   Assumes the bench calls frame to send bytes. */
`timescale 1ns/1ns
module icc_tool_model (
  // Link pins.
  output logic o_serial_clock,
  output logic o_tool_attached,
  output wire o_serial_level,
  input wire logic i_dev_data,
  input wire logic i_dev_oe
);
  logic drv;
  assign o_serial_level = i_dev_oe ? i_dev_data : drv;
  initial begin
    o_serial_clock = 1'b0;
    o_tool_attached = 1'b0;
    drv = 1'b1;
  end
  // Sends one byte; the serial clock stands still outside the frame.
  task frame(input logic [7:0] b);
    int i;
    o_tool_attached = 1'b1;
    for (i = 7; i >= 0; i--) begin
      drv = b[i];
      #160 o_serial_clock = 1'b1;
      #160 o_serial_clock = 1'b0;
    end
    drv = ~b[0];
  endtask
endmodule

//--- verification/tb_top.sv
/* Self-checking bench of the flash access block.
   Assumes the tool model and the checker beside it. */
`timescale 1ns/1ns
module tb_top;
  import flash_access_pkg::*;
  logic I_CLOCK = 1'b0;
  logic I_ARST_N = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata;
  logic sclk, attached, dout, doe, locked, busy, resv;
  wire sdata;
  int n_mismatch = 0;
  int checked = 0;
  int n_oe = 0;
  initial forever #20 I_CLOCK = ~I_CLOCK;
  flash_access_protect #(.PROG_CYCLES(1)) i_flash_access_protect (.I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N),
    .I_REQ(req), .O_RDATA(rdata), .I_SERIAL_CLOCK(sclk), .I_SERIAL_DATA(sdata), .O_SERIAL_DATA(dout),
    .O_SERIAL_DATA_OE(doe), .I_TOOL_ATTACHED(attached), .O_READOUT_LOCKED(locked), .O_BUSY(busy),
    .O_LINK_PINS_RESERVED(resv));
  icc_tool_model i_icc_tool_model (.o_serial_clock(sclk), .o_tool_attached(attached),
    .o_serial_level(sdata), .i_dev_data(dout), .i_dev_oe(doe));
  always @(posedge I_CLOCK) if (doe === 1'b1) n_oe <= n_oe + 1;
  task summarize;
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge I_CLOCK);
    req <= {a, d, 2'b10};
    @(posedge I_CLOCK);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge I_CLOCK);
    req <= {a, 8'h00, 2'b01};
    @(posedge I_CLOCK);
    req.rd <= 1'b0;
    #1 cmp(rdata, exp);
  endtask
  task peek(input logic [15:0] a, input logic [7:0] exp);
    wr(8'h2D, a[7:0]);
    wr(8'h2E, a[15:8]);
    rd(8'h2F, exp);
  endtask
  // Waits for the start of an operation, then for its end.
  task settle(input logic exp);
    int i;
    for (i = 0; i < 4 && busy !== 1'b1; i++) begin
      @(posedge I_CLOCK);
      #1;
    end
    cmp({7'h00, busy}, {7'h00, exp});
    for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
      @(posedge I_CLOCK);
      #1;
    end
    if (busy !== 1'b0) begin
      cmp({7'h00, busy}, 8'h00);
      summarize;
    end
  endtask
  task op(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d, input logic exp);
    wr(8'h2D, a[7:0]);
    wr(8'h2E, a[15:8]);
    rd(8'h2E, a[15:8]);
    wr(8'h2F, d);
    wr(8'h2A, 8'h56);
    wr(8'h2A, 8'hAE);
    wr(8'h29, cmd);
    settle(exp);
  endtask
  initial begin
    repeat (10) @(posedge I_CLOCK);
    I_ARST_N <= 1'b1;
    rd(8'h29, 8'h00);
    i_icc_tool_model.frame(8'hA5);
    repeat (8) @(posedge I_CLOCK);
    #1 cmp({7'h00, resv}, 8'h01);
    cmp(n_oe[7:0], 8'h01);
    wr(8'h2C, 8'h03);
    wr(8'h29, 8'h09);
    settle(1'b0);
    op(8'h09, 16'hE000, 8'hFF, 1'b1);
    peek(16'hF000, 8'hFF);
    op(8'h03, 16'hF000, 8'h3C, 1'b1);
    op(8'h03, 16'hE001, 8'hA5, 1'b1);
    peek(16'hE001, 8'hA5);
    op(8'h05, 16'hE000, 8'h00, 1'b1);
    peek(16'hE001, 8'hFF);
    peek(16'hF000, 8'h3C);
    op(8'h03, 16'hD000, 8'h00, 1'b0);
    wr(8'h2C, 8'h01);
    op(8'h03, 16'hF000, 8'h00, 1'b0);
    op(8'h03, 16'hE002, 8'h0F, 1'b1);
    peek(16'hE002, 8'h0F);
    wr(8'h2C, 8'h03);
    wr(8'h2B, 8'h01);
    repeat (3) @(posedge I_CLOCK);
    #1 cmp({7'h00, locked}, 8'h01);
    peek(16'hF000, 8'h00);
    op(8'h03, 16'hE003, 8'h00, 1'b0);
    wr(8'h2B, 8'h00);
    settle(1'b1);
    cmp({7'h00, locked}, 8'h00);
    peek(16'hF000, 8'hFF);
    summarize;
  end
endmodule
